// File: hdl/sfe_prog.sv
// programmer end: apb-controlled erase sequencer driving the serial link
// assumes apb on ref_clk; the link clock is divided from ref_clk and driven out
`timescale 1ns/100ps
module sfe_prog #(
  parameter int ERASE_CYC = sfe_pkg::ERASE_CYC
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic seq_busy,
  sfe_link_if.prog link
);
  // ==========================================================
  // link clock divider
  logic [1:0] div_ff;
  logic sclk_ff;
  logic fall;
  logic div_wrap;
  assign div_wrap = div_ff == 2'(sfe_pkg::SCLK_HALF - 1);
  assign fall = div_wrap && sclk_ff;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      div_ff <= 2'h0;
      sclk_ff <= 1'b0;
    end else begin
      div_ff <= div_wrap ? 2'h0 : div_ff + 2'h1;
      if (div_wrap) begin
        sclk_ff <= !sclk_ff;
      end
    end
  end

  // ==========================================================
  // link reset: held low over at least one rising link edge
  logic link_rstn_ff;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      link_rstn_ff <= 1'b0;
    end else if (fall) begin
      link_rstn_ff <= 1'b1;
    end
  end

  // ==========================================================
  // apb decode
  logic setup;
  logic access;
  logic mapped;
  logic [7:0] offs;
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign offs = paddr[7:0];
  assign mapped = paddr[31:8] == 24'h000000
                  && (offs == sfe_pkg::A_CTRL || offs == sfe_pkg::A_STATUS
                  || offs == sfe_pkg::A_ROW_OP || offs == sfe_pkg::A_ROW_CNT
                  || offs == sfe_pkg::A_PROGRESS);
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  logic start;
  logic start_bulk;
  logic start_row;
  assign start_bulk = pwdata[sfe_pkg::CTRL_BULK];
  assign start_row = pwdata[sfe_pkg::CTRL_ROW];
  assign start = access && pwrite && mapped && offs == sfe_pkg::A_CTRL
                 && (start_bulk || start_row);

  // ==========================================================
  // software configuration
  logic [15:0] row_op_ff;
  logic [15:0] row_cnt_ff;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      row_op_ff <= sfe_pkg::OP_ROW;
      row_cnt_ff <= sfe_pkg::RST_ROW_CNT;
    end else if (access && pwrite && mapped && !seq_busy) begin
      // writes while a sequence runs would change it midway, so they are dropped
      if (offs == sfe_pkg::A_ROW_OP) begin
        row_op_ff <= pwdata[15:0];
      end
      if (offs == sfe_pkg::A_ROW_CNT) begin
        row_cnt_ff <= pwdata[15:0];
      end
    end
  end

  // ==========================================================
  // sequencer
  sfe_pkg::sfe_state_e state_ff;
  sfe_pkg::sfe_kind_e kind_ff;
  logic [4:0] idx_ff;
  logic [15:0] rows_left_ff;
  logic [31:0] wait_ff;
  logic done_ff;
  logic [4:0] bit_ff;
  logic boundary;
  logic ent_last;
  logic ent_wait;
  logic [23:0] ent_word;
  logic wait_over;

  sfe_seq_rom u_rom (
    .kind(kind_ff),
    .idx(idx_ff),
    .row_op(row_op_ff),
    .last(ent_last),
    .wait_here(ent_wait),
    .word(ent_word)
  );

  assign seq_busy = state_ff != sfe_pkg::ST_IDLE;
  assign boundary = fall && (bit_ff == 5'(sfe_pkg::FRAME_W - 1) || !link_rstn_ff);
  assign wait_over = wait_ff == 32'(ERASE_CYC - 1);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_ff <= sfe_pkg::ST_IDLE;
      kind_ff <= sfe_pkg::KIND_BULK;
      idx_ff <= 5'h00;
      rows_left_ff <= 16'h0000;
      done_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        sfe_pkg::ST_IDLE: begin
          if (start) begin
            // bulk wins when both bits are written together
            kind_ff <= start_bulk ? sfe_pkg::KIND_BULK : sfe_pkg::KIND_ROW;
            idx_ff <= 5'h00;
            rows_left_ff <= row_cnt_ff;
            done_ff <= 1'b0;
            state_ff <= sfe_pkg::ST_RUN;
          end
        end
        sfe_pkg::ST_RUN: begin
          if (boundary && link_rstn_ff) begin
            if (ent_wait) begin
              state_ff <= sfe_pkg::ST_WAIT;
            end else if (ent_last && kind_ff == sfe_pkg::KIND_ROW && rows_left_ff > 16'h0001) begin
              idx_ff <= sfe_pkg::SEQ_ROW_LOOP;
              rows_left_ff <= rows_left_ff - 16'h0001;
            end else if (ent_last) begin
              rows_left_ff <= 16'h0000;
              done_ff <= 1'b1;
              state_ff <= sfe_pkg::ST_IDLE;
            end else begin
              idx_ff <= idx_ff + 5'h01;
            end
          end
        end
        sfe_pkg::ST_WAIT: begin
          if (wait_over) begin
            idx_ff <= idx_ff + 5'h01;
            state_ff <= sfe_pkg::ST_RUN;
          end
        end
        default: state_ff <= sfe_pkg::ST_IDLE;
      endcase
    end
  end

  // erase time counted on ref_clk; link keeps carrying no-op frames meanwhile
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wait_ff <= 32'h00000000;
    end else if (state_ff == sfe_pkg::ST_WAIT) begin
      wait_ff <= wait_ff + 32'h00000001;
    end else begin
      wait_ff <= 32'h00000000;
    end
  end

  // ==========================================================
  // frame shifter: a frame is always in flight so the device stays aligned
  logic [27:0] frame_ff;
  logic sdata_ff;
  logic [23:0] next_word;
  logic [27:0] next_frame;
  assign next_word = (state_ff == sfe_pkg::ST_RUN && !ent_wait) ? ent_word : sfe_pkg::I_NOP;
  assign next_frame = {next_word, sfe_pkg::CMD_EXEC};

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      frame_ff <= 28'h0000000;
      bit_ff <= 5'h00;
      sdata_ff <= 1'b0;
    end else if (boundary) begin
      frame_ff <= next_frame;
      bit_ff <= 5'h00;
      sdata_ff <= next_frame[0];
    end else if (fall) begin
      bit_ff <= bit_ff + 5'h01;
      sdata_ff <= frame_ff[bit_ff + 5'h01];
    end
  end

  assign link.serial_clock_pin = sclk_ff;
  assign link.serial_data_pin = sdata_ff;
  assign link.link_rstn = link_rstn_ff;

  // ==========================================================
  // read path: sampled in the setup cycle, stable through access
  logic [31:0] rd_ff;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rd_ff <= 32'h00000000;
    end else if (setup && !mapped) begin
      // upper address bits are decoded and do not alias the map, so unmapped reads are forced to zero
      rd_ff <= 32'h00000000;
    end else if (setup) begin
      unique case (offs)
        sfe_pkg::A_STATUS: rd_ff <= {30'h00000000, done_ff, seq_busy};
        sfe_pkg::A_ROW_OP: rd_ff <= {16'h0000, row_op_ff};
        sfe_pkg::A_ROW_CNT: rd_ff <= {16'h0000, row_cnt_ff};
        sfe_pkg::A_PROGRESS: rd_ff <= {11'h000, idx_ff, rows_left_ff};
        default: rd_ff <= 32'h00000000;
      endcase
    end
  end
  assign prdata = rd_ff;
endmodule : sfe_prog

// File: hdl/sfe_pkg.sv
// constants shared by both ends of the serial erase-cycle link
// assumes a 50 MHz reference clock on the programmer end
// Function
// - programmer unlocks before starting any cycle
// - setting write_start begins the selected cycle
// - clearing write_start ends the cycle
// - programmer times each cycle, about 2 ms
// - bulk-erase code selects everything plus protection bits
// - command code sent LSB first, clocked serially
// - erase program memory before any write
// - sequence starts with two jumps, one nop
// - unlock writes 0x55 then 0xaa to key
// - set, nops, wait, clear, more nops
// - rows may be erased one at a time
// - row erase keeps code-protect bits unchanged
// - clear row address, keep 0x40 increment
// - row-erase code selects one 32-word row
// - segment erase substitutes its own code
// - execute command shifts 24-bit word, executes
// - write_start locked unless key just written
// - advance row address, carry into high part
package sfe_pkg;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 50;
  localparam int ERASE_TIME_MS = 2;
  localparam int ERASE_CYC = ERASE_TIME_MS * CLK_MHZ * 1000;
  localparam int SCLK_HALF = 2;
  // ==========================================================
  // serial framing
  localparam int CMD_W = 4;
  localparam int WORD_W = 24;
  localparam int FRAME_W = CMD_W + WORD_W;
  localparam logic [3:0] CMD_EXEC = 4'h0;
  // ==========================================================
  // control register layout and codes
  localparam int WS_BIT = 15;
  localparam logic [15:0] OP_BULK = 16'h407f;
  localparam logic [15:0] OP_ROW = 16'h4071;
  localparam logic [15:0] KEY_FIRST = 16'h0055;
  localparam logic [15:0] KEY_SECOND = 16'h00aa;
  localparam logic [11:0] FA_CTL = 12'h3b0;
  localparam logic [11:0] FA_LO = 12'h3b1;
  localparam logic [11:0] FA_HI = 12'h3b2;
  localparam logic [11:0] FA_KEY = 12'h3b3;
  // ==========================================================
  // instruction words and decode patterns
  localparam logic [23:0] I_NOP = 24'h000000;
  localparam logic [23:0] I_GOTO = 24'h040100;
  localparam logic [23:0] I_SET_WS = 24'ha8e761;
  localparam logic [23:0] I_CLR_WS = 24'ha9e761;
  localparam logic [23:0] I_SKIP_NC = 24'haf0042;
  localparam logic [23:0] I_INC_HIGH = 24'hec2764;
  localparam logic [23:0] I_CLR_W6 = 24'heb0300;
  localparam logic [23:0] I_ADD_ROW = 24'h430307;
  localparam logic [23:0] I_KEY1 = 24'h200558;
  localparam logic [23:0] I_KEY1_ST = 24'h883b38;
  localparam logic [23:0] I_KEY2 = 24'h200aa9;
  localparam logic [23:0] I_KEY2_ST = 24'h883b39;
  localparam logic [23:0] I_CTL_ST = 24'h883b0a;
  localparam logic [23:0] I_LO_ST = 24'h883b16;
  localparam logic [23:0] I_HI_ST = 24'h883b26;
  localparam logic [23:0] I_INC_W7 = 24'h200407;
  localparam logic [3:0] MOVL_OPC = 4'h2;
  localparam logic [3:0] OP_REG = 4'ha;
  localparam logic [7:0] MOVST_OPC = 8'h88;
  localparam logic [4:0] ADD_OPC = 5'h08;
  localparam logic [23:0] CLR_MASK = 24'hfff87f;
  localparam logic [23:0] CLR_MATCH = 24'heb0000;
  // ==========================================================
  // programmer register map (apb byte offsets)
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_ROW_OP = 8'h08;
  localparam logic [7:0] A_ROW_CNT = 8'h0c;
  localparam logic [7:0] A_PROGRESS = 8'h10;
  localparam int CTRL_BULK = 0;
  localparam int CTRL_ROW = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam logic [15:0] RST_ROW_CNT = 16'h0001;
  // ==========================================================
  // sequencer
  localparam logic [4:0] SEQ_ROW_LOOP = 5'h07;
  localparam logic [4:0] SEQ_BULK_LAST = 5'h13;
  localparam logic [4:0] SEQ_ROW_LAST = 5'h17;
  typedef enum logic {KIND_BULK = 1'b0, KIND_ROW = 1'b1} sfe_kind_e;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_WAIT = 2'b10} sfe_state_e;
  typedef enum logic [1:0] {KEY_IDLE = 2'b00, KEY_HALF = 2'b01, KEY_OPEN = 2'b10} sfe_key_e;
endpackage : sfe_pkg

// File: hdl/sfe_link_if.sv
// two-wire serial link plus a link reset between programmer and device
// assumes the programmer owns both the clock and the data wire
`timescale 1ns/100ps
interface sfe_link_if;
  logic serial_clock_pin;
  logic serial_data_pin;
  logic link_rstn;
  modport prog (output serial_clock_pin, output serial_data_pin, output link_rstn);
  modport dev (input serial_clock_pin, input serial_data_pin, input link_rstn);
endinterface : sfe_link_if

// File: hdl/sfe_device.sv
// device end: serial instruction receiver and erase-cycle control
// assumes the link clock is its only clock; link_rstn is synchronous to it
`timescale 1ns/100ps
module sfe_device (
  sfe_link_if.dev link,
  output logic cycle_run,
  output logic [15:0] cycle_op,
  output logic protect_erase,
  output logic row_erase,
  output logic [15:0] row_addr_low,
  output logic [7:0] row_addr_high,
  output logic unlocked
);
  // ==========================================================
  // frame receiver
  logic [4:0] bit_cnt_ff;
  logic [27:0] sr_ff;
  logic [27:0] frame;
  logic [23:0] word;
  logic exec;
  logic run_ok;
  assign frame = {link.serial_data_pin, sr_ff[27:1]};
  assign word = frame[27:4];
  assign exec = (bit_cnt_ff == 5'(sfe_pkg::FRAME_W - 1)) && (frame[3:0] == sfe_pkg::CMD_EXEC);

  always_ff @(posedge link.serial_clock_pin) begin
    if (!link.link_rstn) begin
      bit_cnt_ff <= 5'h00;
      sr_ff <= 28'h0000000;
    end else begin
      sr_ff <= frame;
      // reserved codes are swallowed: their frame is simply not executed
      bit_cnt_ff <= (bit_cnt_ff == 5'(sfe_pkg::FRAME_W - 1)) ? 5'h00 : bit_cnt_ff + 5'h01;
    end
  end

  // ==========================================================
  // instruction decode
  logic skip_ff;
  logic carry_ff;
  logic [15:0] w_ff [16];
  logic [15:0] src;
  logic [16:0] sum;
  logic is_movl;
  logic is_movst;
  logic is_add;
  logic is_clr;
  assign run_ok = exec && !skip_ff;
  assign src = w_ff[word[3:0]];
  assign sum = {1'b0, w_ff[word[18:15]]} + {1'b0, src};
  assign is_movl = word[23:20] == sfe_pkg::MOVL_OPC;
  assign is_movst = word[23:16] == sfe_pkg::MOVST_OPC;
  assign is_add = word[23:19] == sfe_pkg::ADD_OPC;
  assign is_clr = (word & sfe_pkg::CLR_MASK) == sfe_pkg::CLR_MATCH;

  always_ff @(posedge link.serial_clock_pin) begin
    if (!link.link_rstn) begin
      for (int i = 0; i < 16; i++) begin
        w_ff[i] <= 16'h0000;
      end
      carry_ff <= 1'b0;
    end else if (run_ok) begin
      if (is_movl) begin
        w_ff[word[3:0]] <= word[19:4];
      end else if (is_clr) begin
        w_ff[word[10:7]] <= 16'h0000;
      end else if (is_add) begin
        w_ff[word[10:7]] <= sum[15:0];
        carry_ff <= sum[16];
      end
    end
  end

  // a skip-if-no-carry suppresses the very next executed word only
  always_ff @(posedge link.serial_clock_pin) begin
    if (!link.link_rstn) begin
      skip_ff <= 1'b0;
    end else if (exec) begin
      skip_ff <= run_ok && (word == sfe_pkg::I_SKIP_NC) && !carry_ff;
    end
  end

  // ==========================================================
  // unlock key tracking: any other executed word relocks, except a literal load while half unlocked
  sfe_pkg::sfe_key_e key_ff;
  always_ff @(posedge link.serial_clock_pin) begin
    if (!link.link_rstn) begin
      key_ff <= sfe_pkg::KEY_IDLE;
    end else if (run_ok) begin
      if (is_movst && word[15:4] == sfe_pkg::FA_KEY && src == sfe_pkg::KEY_FIRST) begin
        key_ff <= sfe_pkg::KEY_HALF;
      end else if (is_movst && word[15:4] == sfe_pkg::FA_KEY && src == sfe_pkg::KEY_SECOND
                   && key_ff == sfe_pkg::KEY_HALF) begin
        key_ff <= sfe_pkg::KEY_OPEN;
      end else if (is_movl && key_ff == sfe_pkg::KEY_HALF) begin
        // loading the second key value into a working register must not relock
        key_ff <= sfe_pkg::KEY_HALF;
      end else begin
        key_ff <= sfe_pkg::KEY_IDLE;
      end
    end
  end
  assign unlocked = key_ff == sfe_pkg::KEY_OPEN;

  // ==========================================================
  // control register and row address
  logic [15:0] ctl_ff;
  logic [15:0] lo_ff;
  logic [7:0] hi_ff;
  always_ff @(posedge link.serial_clock_pin) begin
    if (!link.link_rstn) begin
      ctl_ff <= 16'h0000;
    end else if (run_ok) begin
      if (is_movst && word[15:4] == sfe_pkg::FA_CTL) begin
        // the start bit cannot be reached by a plain move
        ctl_ff[sfe_pkg::WS_BIT - 1:0] <= src[sfe_pkg::WS_BIT - 1:0];
      end else if (word == sfe_pkg::I_SET_WS && unlocked) begin
        ctl_ff[sfe_pkg::WS_BIT] <= 1'b1;
      end else if (word == sfe_pkg::I_CLR_WS) begin
        ctl_ff[sfe_pkg::WS_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge link.serial_clock_pin) begin
    if (!link.link_rstn) begin
      lo_ff <= 16'h0000;
      hi_ff <= 8'h00;
    end else if (run_ok) begin
      if (is_movst && word[15:4] == sfe_pkg::FA_LO) begin
        lo_ff <= src;
      end else if (is_movst && word[15:4] == sfe_pkg::FA_HI) begin
        hi_ff <= src[7:0];
      end else if (word == sfe_pkg::I_INC_HIGH) begin
        hi_ff <= hi_ff + 8'h01;
      end
    end
  end

  // no self-timed completion: the cycle lasts exactly while the start bit is set
  assign cycle_run = ctl_ff[sfe_pkg::WS_BIT];
  assign cycle_op = ctl_ff;
  assign protect_erase = cycle_run && ctl_ff[14:0] == sfe_pkg::OP_BULK[14:0];
  assign row_erase = cycle_run && ctl_ff[14:0] == sfe_pkg::OP_ROW[14:0];
  assign row_addr_low = lo_ff;
  assign row_addr_high = hi_ff;
endmodule : sfe_device

// File: hdl/sfe_seq_rom.sv
// instruction sequences for bulk and row erase, indexed by step
// assumes the caller loops rows and stretches the wait entry
`timescale 1ns/100ps
module sfe_seq_rom (
  input wire sfe_pkg::sfe_kind_e kind,
  input wire logic [4:0] idx,
  input wire logic [15:0] row_op,
  output logic last,
  output logic wait_here,
  output logic [23:0] word
);
  always_comb begin
    last = 1'b0;
    wait_here = 1'b0;
    word = sfe_pkg::I_NOP;
    if (kind == sfe_pkg::KIND_BULK) begin
      unique case (idx)
        5'h00, 5'h01: word = sfe_pkg::I_GOTO;
        5'h03: word = {sfe_pkg::MOVL_OPC, sfe_pkg::OP_BULK, sfe_pkg::OP_REG};
        5'h04: word = sfe_pkg::I_CTL_ST;
        5'h05: word = sfe_pkg::I_KEY1;
        5'h06: word = sfe_pkg::I_KEY1_ST;
        5'h07: word = sfe_pkg::I_KEY2;
        5'h08: word = sfe_pkg::I_KEY2_ST;
        5'h09: word = sfe_pkg::I_SET_WS;
        5'h0e: wait_here = 1'b1;
        5'h0f: word = sfe_pkg::I_CLR_WS;
        sfe_pkg::SEQ_BULK_LAST: last = 1'b1;
        default: word = sfe_pkg::I_NOP;
      endcase
    end else begin
      unique case (idx)
        5'h00, 5'h01: word = sfe_pkg::I_GOTO;
        5'h03: word = sfe_pkg::I_CLR_W6;
        5'h04: word = sfe_pkg::I_LO_ST;
        5'h05: word = sfe_pkg::I_HI_ST;
        5'h06: word = sfe_pkg::I_INC_W7;
        5'h07: word = {sfe_pkg::MOVL_OPC, row_op, sfe_pkg::OP_REG};
        5'h08: word = sfe_pkg::I_CTL_ST;
        5'h09: word = sfe_pkg::I_KEY1;
        5'h0a: word = sfe_pkg::I_KEY1_ST;
        5'h0b: word = sfe_pkg::I_KEY2;
        5'h0c: word = sfe_pkg::I_KEY2_ST;
        5'h0d: word = sfe_pkg::I_SET_WS;
        5'h0f: wait_here = 1'b1;
        5'h10: word = sfe_pkg::I_CLR_WS;
        5'h12: word = sfe_pkg::I_ADD_ROW;
        5'h13: word = sfe_pkg::I_SKIP_NC;
        5'h14: word = sfe_pkg::I_INC_HIGH;
        5'h15: word = sfe_pkg::I_LO_ST;
        5'h16: word = sfe_pkg::I_GOTO;
        sfe_pkg::SEQ_ROW_LAST: last = 1'b1;
        default: word = sfe_pkg::I_NOP;
      endcase
    end
  end
endmodule : sfe_seq_rom

// File: bench/sfe_link_monitor.sv
// checker for the erase-cycle link: watches the wires and the device end outputs
// assumes the link clock and link reset carried by the joining interface
`timescale 1ns/100ps
module sfe_link_monitor #(
  parameter int MIN_RUN = 50
) (
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin,
  input wire logic link_rstn,
  input wire logic cycle_run,
  input wire logic [15:0] cycle_op,
  input wire logic protect_erase,
  input wire logic row_erase,
  input wire logic [15:0] row_addr_low,
  input wire logic [7:0] row_addr_high,
  input wire logic unlocked
);
  logic [15:0] run_len_ff;
  logic [15:0] nxt_run_len;
  // ==========================================================
  // length of the running cycle; saturates so a stuck bit cannot wrap to a short count
  assign nxt_run_len = !cycle_run ? 16'h0 : (&run_len_ff) ? run_len_ff : run_len_ff + 16'h1;
  always_ff @(posedge serial_clock_pin) begin
    if (!link_rstn) begin
      run_len_ff <= 16'h0;
    end else begin
      run_len_ff <= nxt_run_len;
    end
  end
  // ==========================================================
  // assertions
  default clocking @(posedge serial_clock_pin); endclocking
  default disable iff (!link_rstn);
  property p_run_bit;
    cycle_run == cycle_op[sfe_pkg::WS_BIT];
  endproperty
  a_run_bit: assert property (p_run_bit) else $error("cycle flag differs from start bit");
  property p_bulk_sel;
    protect_erase == (cycle_run && cycle_op[14:0] == sfe_pkg::OP_BULK[14:0]);
  endproperty
  a_bulk_sel: assert property (p_bulk_sel) else $error("bulk erase select wrong");
  property p_row_sel;
    row_erase == (cycle_run && cycle_op[14:0] == sfe_pkg::OP_ROW[14:0]);
  endproperty
  a_row_sel: assert property (p_row_sel) else $error("row erase select wrong");
  property p_key_gate;
    $rose(cycle_run) |-> $past(unlocked) && !unlocked;
  endproperty
  a_key_gate: assert property (p_key_gate) else $error("cycle started while locked");
  property p_key_hold;
    $rose(unlocked) |-> ##27 unlocked ##1 !unlocked;
  endproperty
  a_key_hold: assert property (p_key_hold) else $error("unlock not held one frame");
  property p_op_hold;
    $rose(cycle_run) |=> $stable(cycle_op) [*8];
  endproperty
  a_op_hold: assert property (p_op_hold) else $error("control changed inside frame");
  property p_addr_hold;
    cycle_run |=> $stable(row_addr_low) && $stable(row_addr_high);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("row address moved during cycle");
  property p_run_len;
    $fell(cycle_run) && $past(link_rstn) |-> run_len_ff >= MIN_RUN;
  endproperty
  a_run_len: assert property (p_run_len) else $error("erase cycle too short");
endmodule : sfe_link_monitor

// File: bench/testbench.sv
// self-checking bench: programmer end and device end joined over the link
// assumes the design package, link interface and both ends compile first
`timescale 1ns/100ps
module testbench;
  localparam int ERASE_CYC = 200;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, seq_busy, cycle_run, protect_erase, row_erase, unlocked;
  logic [15:0] cycle_op, row_addr_low;
  logic [7:0] row_addr_high;
  logic [33:0] exp_q[$];
  logic [27:0] win = 28'h0;
  logic run_prev = 1'b0;
  int n_mismatch = 0;
  int checks = 0;
  int seed = 38;
  sfe_link_if link ();
  sfe_prog #(.ERASE_CYC(ERASE_CYC)) u_sfe_prog (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .seq_busy(seq_busy), .link(link));
  sfe_device u_sfe_device (.link(link), .cycle_run(cycle_run), .cycle_op(cycle_op), .protect_erase(protect_erase),
    .row_erase(row_erase), .row_addr_low(row_addr_low), .row_addr_high(row_addr_high), .unlocked(unlocked));
  sfe_link_monitor #(.MIN_RUN(ERASE_CYC / 4)) u_sfe_link_monitor (.serial_clock_pin(link.serial_clock_pin),
    .serial_data_pin(link.serial_data_pin), .link_rstn(link.link_rstn), .cycle_run(cycle_run),
    .cycle_op(cycle_op), .protect_erase(protect_erase), .row_erase(row_erase), .row_addr_low(row_addr_low),
    .row_addr_high(row_addr_high), .unlocked(unlocked));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // shared tasks
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task close_out;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one erase run: note every expected cycle start, launch, then poll until idle
  task run_erase(input string name, input logic [31:0] ctl, input logic [15:0] op, input int rows);
    logic [31:0] r;
    logic e;
    int k;
    for (k = 0; k < rows; k++) begin
      exp_q.push_back({op[14:0] == sfe_pkg::OP_BULK[14:0], op[14:0] == sfe_pkg::OP_ROW[14:0], 1'b1, op[14:0],
        ctl[0] ? 16'h0 : 16'(k * 64)});
    end
    apb(1'b1, {24'h0, sfe_pkg::A_CTRL}, ctl, r, e);
    // a row count written while busy must not land
    apb(1'b1, {24'h0, sfe_pkg::A_ROW_CNT}, 32'h7, r, e);
    k = 0;
    do begin
      apb(1'b0, {24'h0, sfe_pkg::A_STATUS}, 32'h0, r, e);
      k++;
    end while (r[sfe_pkg::ST_BUSY] !== 1'b0 && k < 8000);
    check("status", r, 32'h2);
    check("pending starts", 32'(exp_q.size()), 32'h0);
    apb(1'b0, {24'h0, sfe_pkg::A_ROW_CNT}, 32'h0, r, e);
    check("row count", r, 32'(rows));
    $display("test %s done", name);
  endtask : run_erase
  // ==========================================================
  // wire capture and result watcher; bits arrive lsb first
  always @(posedge link.serial_clock_pin) begin
    win <= {link.serial_data_pin, win[27:1]};
  end
  always @(negedge link.serial_clock_pin) begin : watch
    logic [33:0] n;
    if (cycle_run === 1'b1 && run_prev !== 1'b1) begin
      check("start frame", {4'h0, win}, {4'h0, sfe_pkg::I_SET_WS, sfe_pkg::CMD_EXEC});
      if (exp_q.size() == 0) begin
        check("unexpected start", 32'h1, 32'h0);
      end else begin
        n = exp_q.pop_front();
        check("protect_erase", {31'h0, protect_erase}, {31'h0, n[33]});
        check("row_erase", {31'h0, row_erase}, {31'h0, n[32]});
        check("cycle_op", {16'h0, cycle_op}, {16'h0, n[31:16]});
        check("row_addr_low", {16'h0, row_addr_low}, {16'h0, n[15:0]});
        check("row_addr_high", {24'h0, row_addr_high}, 32'h0);
      end
    end
    run_prev <= cycle_run;
  end
  // ==========================================================
  // main sequence
  initial begin : main
    logic [31:0] r;
    logic [31:0] rnd;
    logic e;
    logic [31:0] addrs[6];
    logic [31:0] vals[6];
    addrs = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10, 32'h108};
    vals = '{32'h0, 32'h0, 32'h4071, 32'h1, 32'h0, 32'h0};
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, addrs[i], 32'h0, r, e);
      check("reset read", r, vals[i]);
      check("slave error", {31'h0, e}, {31'h0, i == 5});
    end
    // aliased unmapped write: the bulk run later checks the row count is still at reset
    apb(1'b1, 32'h10c, 32'h5, r, e);
    check("unmapped write", {31'h0, e}, 32'h1);
    $display("test registers done");
    run_erase("bulk", 32'h3, sfe_pkg::OP_BULK, 1);
    rnd = $random(seed);
    apb(1'b1, {24'h0, sfe_pkg::A_ROW_CNT}, 32'h2 + {31'h0, rnd[0]}, r, e);
    run_erase("row", 32'h2, sfe_pkg::OP_ROW, 2 + int'(rnd[0]));
    apb(1'b1, {24'h0, sfe_pkg::A_ROW_OP}, 32'h406e, r, e);
    apb(1'b1, {24'h0, sfe_pkg::A_ROW_CNT}, 32'h1, r, e);
    run_erase("segment", 32'h2, 16'h406e, 1);
    close_out();
  end
  initial begin
    #1000000;
    n_mismatch++;
    close_out();
  end
endmodule : testbench
